// >>> src/mhic_pkg.sv
// Constants and types shared by the memory hub interrupt controller.
package mhic_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NPORT = 8;
	localparam int AW = 18;
	localparam int DW = 72;
	localparam int NCELL = 32;
	localparam int TMW = 36;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_NS = 20;
	localparam int MEM_SLOW_NS = 1200;
	localparam int MEM_FAST_NS = 500;
	// Memory cycles are least times, so they round up.
	localparam int MEM_SLOW_CYC = (MEM_SLOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int MEM_FAST_CYC = (MEM_FAST_NS + CLK_NS - 1) / CLK_NS;
	localparam int TICKS_PER_MS = 512;
	localparam int NS_PER_MS = 1000000;
	// The clock tick period rounds down to whole cycles.
	localparam int TICK_CYC = NS_PER_MS / (TICKS_PER_MS * CLK_NS);

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_LOCK = 8'h00;
	localparam logic [7:0] REG_IEN = 8'h04;
	localparam logic [7:0] REG_CELLS = 8'h08;
	localparam logic [7:0] REG_TLO = 8'h0C;
	localparam logic [7:0] REG_THI = 8'h10;
	localparam logic [7:0] REG_STS = 8'h14;
	localparam logic [7:0] REG_MSK = 8'h18;
	localparam logic [7:0] REG_SW = 8'h1C;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] LOCK_RST = 8'h00;
	localparam logic [31:0] IEN_RST = 32'h00000000;
	localparam logic [3:0] MSK_RST = 4'h0;

	// ----------------------------------------------------------------
	// Status bit positions
	// ----------------------------------------------------------------
	localparam int ST_CELL = 0;
	localparam int ST_LOCK = 1;
	localparam int ST_PAR = 2;
	localparam int ST_WRAP = 3;

	// ----------------------------------------------------------------
	// Switch vector field positions
	// ----------------------------------------------------------------
	localparam int SW_PRIO = 0;
	localparam int SW_DESIG = 3;
	localparam int SW_FAST = 6;
	localparam int SW_ILV2 = 7;
	localparam int SW_ILV4 = 8;
	localparam int SW_CTL = 9;
	localparam int SW_W = 10;

	// ----------------------------------------------------------------
	// Bus answers and memory sequencer states
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		MH_IDLE,
		MH_CYCLE,
		MH_DONE
	} mhic_mstate_t;

endpackage

// >>> src/mhic_top.sv
// Memory hub with port arbiter, lockout, elapsed clock and interrupt cells.
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns

module mhic_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq,
	input wire logic [2:0] prio_sw,
	input wire logic [2:0] desig_sw,
	input wire logic fast_sw,
	input wire logic ilv2_sw,
	input wire logic ilv4_sw,
	input wire logic ctl_id_sw,
	input wire logic [7:0] port_req,
	input wire logic [7:0] port_we,
	input wire logic [143:0] port_addr,
	input wire logic [575:0] port_wdata,
	output logic [7:0] port_grant,
	output logic [7:0] port_done,
	output logic [7:0] port_reject,
	output logic [71:0] port_rdata,
	output logic port_perr,
	input wire logic [7:0] port_int_set,
	input wire logic [39:0] port_int_cell,
	input wire logic [7:0] port_int_ask,
	output logic [7:0] int_pending,
	output logic [7:0] int_ans_valid,
	output logic [4:0] int_ans_cell,
	output logic int_ans_none,
	output logic mem_start,
	output logic mem_we,
	output logic mem_unit,
	output logic [16:0] mem_addr,
	output logic [73:0] mem_wdata,
	input wire logic [73:0] mem_rdata
);

	// ----------------------------------------------------------------
	// State and helpers
	// ----------------------------------------------------------------

	typedef struct packed {
		logic [mhic_pkg::SW_W-1:0] sw1;
		logic [mhic_pkg::SW_W-1:0] sw2;
		logic awv;
		logic [7:0] awa;
		logic wv;
		logic [31:0] wd;
		logic [3:0] ws;
		logic bv;
		logic [1:0] br;
		logic rv;
		logic [1:0] rr;
		logic [31:0] rd;
		logic [7:0] lock;
		logic [31:0] en;
		logic [31:0] cells;
		logic [35:0] tm;
		logic [6:0] tdiv;
		logic [3:0] snap;
		logic [3:0] sts;
		logic [3:0] msk;
		mhic_pkg::mhic_mstate_t st;
		logic [2:0] cur;
		logic [6:0] cyc;
		logic we;
		logic unit;
		logic [16:0] maddr;
		logic [73:0] mwd;
		logic mstart;
		logic [7:0] grant;
		logic [7:0] done;
		logic [7:0] rej;
		logic [71:0] rdat;
		logic perr;
		logic [7:0] aval;
		logic [4:0] acell;
		logic anone;
	} mhic_st_t;

	localparam logic [6:0] SLOW_LAST = 7'(mhic_pkg::MEM_SLOW_CYC - 1);
	localparam logic [6:0] FAST_LAST = 7'(mhic_pkg::MEM_FAST_CYC - 1);
	localparam logic [6:0] TICK_LAST = 7'(mhic_pkg::TICK_CYC - 1);

	mhic_st_t q;
	mhic_st_t d;
	logic [mhic_pkg::SW_W-1:0] sw_in;
	logic [2:0] prio;
	logic [2:0] desig;
	logic fast_w;
	logic [7:0] ok_v;
	logic [7:0] rot;
	logic [2:0] win;
	logic [7:0] lock_req;
	logic [31:0] set_v;
	logic [31:0] clr_v;
	logic [31:0] pend;
	logic ask;
	logic [3:0] ev;
	logic sts_clr;
	logic [17:0] a_sel;
	logic [16:0] pair;
	logic [71:0] wsel;

	// Lowest set bit index; bit 0 is the highest priority.
	function automatic logic [4:0] mhic_first(input logic [31:0] v);
		logic [4:0] n;
		n = 5'h00;
		for (int i = 31; i >= 0; i--) begin
			if (v[i]) begin
				n = 5'(i);
			end
		end
		return n;
	endfunction

	// Merges write data into a register under the byte strobes.
	function automatic logic [31:0] mhic_wr(input logic [31:0] old, input logic [31:0] dat,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = dat[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// Odd parity over one 36-bit word.
	function automatic logic mhic_par(input logic [35:0] w);
		return ~^w;
	endfunction

	// Switch pins enter through two flip-flops; logic reads only the second.
	assign sw_in = {ctl_id_sw, ilv4_sw, ilv2_sw, fast_sw, desig_sw, prio_sw};
	assign prio = q.sw2[mhic_pkg::SW_PRIO +: 3];
	assign desig = q.sw2[mhic_pkg::SW_DESIG +: 3];
	assign fast_w = q.sw2[mhic_pkg::SW_FAST];
	assign lock_req = port_req & q.lock;
	assign pend = q.cells & q.en;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------

	// Computes the whole next state from the current one and the inputs.
	always_comb begin
		d = q;
		ev = 4'h0;
		sts_clr = 1'b0;
		ok_v = 8'h00;
		rot = 8'h00;
		set_v = 32'h00000000;
		clr_v = 32'h00000000;
		ask = 1'b0;
		d.sw1 = sw_in;
		d.sw2 = q.sw1;
		d.grant = 8'h00;
		d.done = 8'h00;
		d.mstart = 1'b0;
		d.aval = 8'h00;
		// locked requests get a reject pulse
		d.rej = lock_req;
		if (lock_req != 8'h00) begin
			ev[mhic_pkg::ST_LOCK] = 1'b1;
		end
		// four-way mode serves only addresses of this controller
		for (int i = 0; i < mhic_pkg::NPORT; i++) begin
			ok_v[i] = port_req[i] & ~q.lock[i] & (q.st == mhic_pkg::MH_IDLE) &
				(~q.sw2[mhic_pkg::SW_ILV4] | (port_addr[i*18+1] == q.sw2[mhic_pkg::SW_CTL]));
		end
		// the priority switch rotates the starting port
		for (int i = 0; i < mhic_pkg::NPORT; i++) begin
			rot[i] = ok_v[3'(i) + prio];
		end
		win = 3'(mhic_first({24'h000000, rot})) + prio;
		// the full 18-bit word address of the winner
		a_sel = port_addr[win*18 +: 18];
		pair = a_sel[17:1];
		wsel = port_wdata[win*72 +: 72];

		// Memory sequencer.
		case (q.st)
			mhic_pkg::MH_IDLE: begin
				// one port at a time is granted
				if (ok_v != 8'h00) begin
					d.cur = win;
					d.grant = 8'h01 << win;
					d.we = port_we[win];
					d.mstart = 1'b1;
					// cycle length follows the speed switch
					d.cyc = fast_w ? FAST_LAST : SLOW_LAST;
					// two words carry one parity bit each
					d.mwd = {mhic_par(wsel[71:36]), mhic_par(wsel[35:0]), wsel};
					// interleaving picks the unit, data is untouched
					if (q.sw2[mhic_pkg::SW_ILV4]) begin
						d.unit = pair[1];
						d.maddr = {2'h0, pair[16:2]};
					end else if (q.sw2[mhic_pkg::SW_ILV2]) begin
						d.unit = pair[0];
						d.maddr = {1'h0, pair[16:1]};
					end else begin
						d.unit = pair[16];
						d.maddr = {1'h0, pair[15:0]};
					end
					d.st = mhic_pkg::MH_CYCLE;
				end
			end
			mhic_pkg::MH_CYCLE: begin
				if (q.cyc == 7'h00) begin
					d.perr = 1'b0;
					// read data is checked word by word
					if (!q.we) begin
						d.rdat = mem_rdata[71:0];
						d.perr = (mem_rdata[73] != mhic_par(mem_rdata[71:36])) |
							(mem_rdata[72] != mhic_par(mem_rdata[35:0]));
						ev[mhic_pkg::ST_PAR] = d.perr;
					end
					d.done = 8'h01 << q.cur;
					d.st = mhic_pkg::MH_DONE;
				end else begin
					d.cyc = q.cyc - 7'h01;
				end
			end
			mhic_pkg::MH_DONE: begin
				d.st = mhic_pkg::MH_IDLE;
			end
			default: begin
				d.st = mhic_pkg::MH_IDLE;
			end
		endcase

		// each unlocked request sets its chosen cell
		for (int i = 0; i < mhic_pkg::NPORT; i++) begin
			if (port_int_set[i]) begin
				if (q.lock[i]) begin
					ev[mhic_pkg::ST_LOCK] = 1'b1;
				end else begin
					set_v[port_int_cell[i*5 +: 5]] = 1'b1;
				end
			end
		end
		ev[mhic_pkg::ST_CELL] = (set_v & ~q.cells) != 32'h00000000;

		// only the designated port may ask for a report
		ask = port_int_ask[desig];
		if (ask) begin
			d.aval = 8'h01 << desig;
			if (pend != 32'h00000000) begin
				// report the top enabled cell and clear it
				d.acell = mhic_first(pend);
				d.anone = 1'b0;
				clr_v[d.acell] = 1'b1;
			end else begin
				d.anone = 1'b1;
			end
		end
		// masked cells stay; a new set wins over the clear
		d.cells = (q.cells & ~clr_v) | set_v;

		if (q.tdiv == TICK_LAST) begin
			d.tdiv = 7'h00;
			d.tm = q.tm + 36'h1;
			ev[mhic_pkg::ST_WRAP] = &q.tm;
		end else begin
			d.tdiv = q.tdiv + 7'h01;
		end

		// Register bus write side.
		if (s_axi_awvalid && s_axi_awready) begin
			d.awv = 1'b1;
			d.awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			d.wv = 1'b1;
			d.wd = s_axi_wdata;
			d.ws = s_axi_wstrb;
		end
		if (q.awv && q.wv && !q.bv) begin
			d.awv = 1'b0;
			d.wv = 1'b0;
			d.bv = 1'b1;
			d.br = mhic_pkg::RESP_OKAY;
			case (q.awa)
				mhic_pkg::REG_LOCK: d.lock = 8'(mhic_wr({24'h000000, q.lock}, q.wd, q.ws));
				// software loads the cell enable mask
				mhic_pkg::REG_IEN: d.en = mhic_wr(q.en, q.wd, q.ws);
				mhic_pkg::REG_MSK: d.msk = 4'(mhic_wr({28'h0000000, q.msk}, q.wd, q.ws));
				mhic_pkg::REG_CELLS, mhic_pkg::REG_TLO, mhic_pkg::REG_THI,
				mhic_pkg::REG_STS, mhic_pkg::REG_SW: d.br = mhic_pkg::RESP_OKAY;
				default: d.br = mhic_pkg::RESP_SLVERR;
			endcase
		end
		if (q.bv && s_axi_bready) begin
			d.bv = 1'b0;
		end

		// Register bus read side.
		if (s_axi_arvalid && s_axi_arready) begin
			d.rv = 1'b1;
			d.rr = mhic_pkg::RESP_OKAY;
			d.rd = 32'h00000000;
			case (s_axi_araddr)
				mhic_pkg::REG_LOCK: d.rd = {24'h000000, q.lock};
				mhic_pkg::REG_IEN: d.rd = q.en;
				mhic_pkg::REG_CELLS: d.rd = q.cells;
				mhic_pkg::REG_TLO: begin
					d.rd = q.tm[31:0];
					d.snap = q.tm[35:32];
				end
				mhic_pkg::REG_THI: d.rd = {28'h0000000, q.snap};
				mhic_pkg::REG_STS: begin
					d.rd = {28'h0000000, q.sts};
					sts_clr = 1'b1;
				end
				mhic_pkg::REG_MSK: d.rd = {28'h0000000, q.msk};
				mhic_pkg::REG_SW: d.rd = {22'h000000, q.sw2};
				default: d.rr = mhic_pkg::RESP_SLVERR;
			endcase
		end
		if (q.rv && s_axi_rready) begin
			d.rv = 1'b0;
		end
		// Events arriving during a clearing read are kept.
		d.sts = (sts_clr ? 4'h0 : q.sts) | ev;
	end

	// Registers the state; a low clock enable freezes everything.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.lock <= mhic_pkg::LOCK_RST;
			q.en <= mhic_pkg::IEN_RST;
			q.msk <= mhic_pkg::MSK_RST;
		end else if (ce) begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------

	// The three ready outputs are gated by the clock enable; bvalid and rvalid are not.
	assign s_axi_awready = ce & ~q.awv & ~q.bv;
	assign s_axi_wready = ce & ~q.wv & ~q.bv;
	assign s_axi_arready = ce & ~q.rv;
	assign s_axi_bvalid = q.bv;
	assign s_axi_bresp = q.br;
	assign s_axi_rvalid = q.rv;
	assign s_axi_rresp = q.rr;
	assign s_axi_rdata = q.rd;
	assign irq = (q.sts & q.msk) != 4'h0;

	// Port, storage and interrupt answers come straight from state.
	assign port_grant = q.grant;
	assign port_done = q.done;
	assign port_reject = q.rej;
	assign port_rdata = q.rdat;
	assign port_perr = q.perr;
	assign mem_start = q.mstart;
	assign mem_we = q.we;
	assign mem_unit = q.unit;
	assign mem_addr = q.maddr;
	assign mem_wdata = q.mwd;
	assign int_ans_valid = q.aval;
	assign int_ans_cell = q.acell;
	assign int_ans_none = q.anone;
	// masked cells never show as pending
	assign int_pending = (8'h01 << desig) & {8{pend != 32'h00000000}};

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_grant_onehot: assert property ($onehot0(port_grant))
		else $error("more than one port granted");
	a_port0_first: assert property ((ce && ok_v[0] && prio == 3'h0) |=> port_grant[0])
		else $error("port zero lost arbitration");
	a_switch_prio: assert property ((ce && ok_v[prio]) |=>
		port_grant == (8'h01 << $past(prio)))
		else $error("switch priority ignored");
	a_lock_reject: assert property (ce |=> (port_reject == $past(lock_req)) &&
		((port_grant & $past(lock_req)) == 8'h00))
		else $error("locked port not refused");
	a_cell_set: assert property ((ce && set_v != 32'h0) |=>
		(q.cells & $past(set_v)) == $past(set_v))
		else $error("interrupt cell not set");
	a_enable_none: assert property ((ce && ask && pend == 32'h0) |=> int_ans_none)
		else $error("disabled cell reported");
	a_desig_only: assert property ((int_ans_valid != 8'h00) |->
		int_ans_valid == (8'h01 << $past(desig)))
		else $error("answer on wrong port");
	a_time_tick: assert property ((ce && q.tdiv == TICK_LAST) |=>
		q.tm == $past(q.tm) + 36'h1)
		else $error("elapsed clock did not advance");
	a_pair_parity: assert property ((mem_start && mem_we) |->
		mem_wdata[73] == ~^mem_wdata[71:36] && mem_wdata[72] == ~^mem_wdata[35:0])
		else $error("bad write parity");
	a_cycle_load: assert property (mem_start |->
		q.cyc == ($past(fast_w) ? FAST_LAST : SLOW_LAST))
		else $error("wrong memory cycle length");
	a_report_clear: assert property ((ce && ask && pend != 32'h0 && set_v == 32'h0) |=>
		!q.cells[q.acell] && !int_ans_none)
		else $error("reported cell not cleared");
	a_masked_quiet: assert property ((pend == 32'h0) |-> int_pending == 8'h00)
		else $error("masked cell shown pending");
	a_cell_hold: assert property ((ce && !ask) |=>
		(q.cells & $past(q.cells)) == $past(q.cells))
		else $error("pending cell lost");

endmodule

// >>> test/mhic_store_model.sv
// Behavioural core storage that sits behind the memory hub.
`timescale 1ns/1ns
module mhic_store_model (
	input wire logic aclk,
	input wire logic mem_start,
	input wire logic mem_we,
	input wire logic mem_unit,
	input wire logic [16:0] mem_addr,
	input wire logic [73:0] mem_wdata,
	input wire logic bad_par,
	output logic [73:0] mem_rdata
);
	// ----------------------------------------------------------------
	// Storage array
	// ----------------------------------------------------------------
	logic [73:0] store [logic [17:0]];

	initial mem_rdata = 74'h0;

	// Keeps both words with their two parity bits as one unit.
	// pair with parity
	// Writes and reads of unwritten addresses toggle the data lines, so stale values never look valid.
	always @(posedge aclk) begin
		if (mem_start && mem_we) begin
			store[{mem_unit, mem_addr}] = mem_wdata;
			mem_rdata <= ~mem_rdata;
		end else if (mem_start && store.exists({mem_unit, mem_addr})) begin
			mem_rdata <= store[{mem_unit, mem_addr}] ^ {1'b0, bad_par, 72'h0};
		end else if (mem_start) begin
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule

// >>> test/test_mhic_top.sv
// Self-checking bench for the memory hub interrupt controller.
`timescale 1ns/1ns
module test_mhic_top;
	logic aclk, aresetn, awv, wv, bready, arv, rready, fast, ilv2, ilv4, ctl, bad;
	logic [7:0] awaddr, araddr, req, we, iset_v, ask_v;
	logic [31:0] wdata, ien;
	logic [2:0] prio, desig;
	logic [143:0] addr;
	logic [575:0] wd;
	logic [39:0] icell;
	logic [17:0] a3, a6;
	logic [71:0] d3, d6;
	logic awr, wrdy, arr, bvalid, rvalid, irq, perr, none, mst, mwe, munit;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] grant, done, rej, pend, ansv;
	logic [4:0] acell;
	logic [71:0] prd;
	logic [16:0] maddr;
	logic [73:0] mwd, mrd;
	logic [81:0] rq[$], aq[$], dq[$], wq[$], e;
	int err_total, n_compared, ncyc;

	mhic_top dut (
		.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.irq(irq), .prio_sw(prio), .desig_sw(desig), .fast_sw(fast), .ilv2_sw(ilv2),
		.ilv4_sw(ilv4), .ctl_id_sw(ctl), .port_req(req), .port_we(we), .port_addr(addr),
		.port_wdata(wd), .port_grant(grant), .port_done(done), .port_reject(rej),
		.port_rdata(prd), .port_perr(perr), .port_int_set(iset_v), .port_int_cell(icell),
		.port_int_ask(ask_v), .int_pending(pend), .int_ans_valid(ansv), .int_ans_cell(acell),
		.int_ans_none(none), .mem_start(mst), .mem_we(mwe), .mem_unit(munit),
		.mem_addr(maddr), .mem_wdata(mwd), .mem_rdata(mrd)
	);

	mhic_store_model store (.aclk(aclk), .mem_start(mst), .mem_we(mwe), .mem_unit(munit),
		.mem_addr(maddr), .mem_wdata(mwd), .bad_par(bad), .mem_rdata(mrd));

	// Free-running 50 MHz clock.
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	// ----------------------------------------------------------------
	// Checking and closing
	// ----------------------------------------------------------------
	task automatic chk(input logic [81:0] g, input logic [81:0] x);
		n_compared++;
		if (g !== x) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, g, x);
		end
	endtask

	task automatic wrap_up();
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic to();
		err_total++;
		$display("mismatch at %0t: wait ran out", $time);
		wrap_up();
	endtask

	// Takes the oldest note; a result with no note is itself a mismatch.
	function automatic logic [81:0] pop(ref logic [81:0] q[$]);
		if (q.size() == 0) begin
			err_total++;
			$display("mismatch at %0t: unexpected result", $time);
			return 82'h0;
		end
		return q.pop_front();
	endfunction

	// Compares every result that shows at the outputs with its note.
	always @(negedge aclk) begin
		if (rvalid && rready) chk(82'({rresp, rdata}), pop(rq));
		if (bvalid && bready) chk(82'(bresp), pop(wq));
		// The reported number picks the two vector words, so every bit matters.
		if (ansv != 8'h00) begin
			e = pop(aq);
			chk(82'({ansv, none, acell & {5{!none}}}), 82'({8'h01 << desig, e[5:0]}));
		end
		if (done != 8'h00) begin
			e = pop(dq);
			chk(e[81] ? {1'b1, perr, prd, done} : 82'(done), e);
		end
	end

	// ----------------------------------------------------------------
	// Bus and port drivers
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [2:0] p;
		int n;
		p = 3'b111;
		wq.push_back(82'(mhic_pkg::RESP_OKAY));
		n = 0;
		awaddr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		while (p != 3'b000 && n < 40) begin
			@(negedge aclk);
			if (awv && awr) p[0] = 1'b0;
			if (wv && wrdy) p[1] = 1'b0;
			if (bvalid && bready) p[2] = 1'b0;
			@(posedge aclk);
			awv <= p[0];
			wv <= p[1];
			bready <= p[2];
			n++;
		end
		if (n >= 40) to();
		// Lets an edge pass so the next call never re-drives in this step.
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d);
		logic [1:0] p;
		int n;
		rq.push_back(82'({r, d}));
		p = 2'b11;
		n = 0;
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		while (p != 2'b00 && n < 40) begin
			@(negedge aclk);
			if (arv && arr) p[0] = 1'b0;
			if (rvalid && rready) p[1] = 1'b0;
			@(posedge aclk);
			arv <= p[0];
			rready <= p[1];
			n++;
		end
		if (n >= 40) to();
		// Lets an edge pass so the next call never re-drives in this step.
		@(posedge aclk);
	endtask

	task automatic iset(input int i, input logic [4:0] c);
		icell[i*5+:5] <= c;
		iset_v[i] <= 1'b1;
		@(posedge aclk);
		iset_v[i] <= 1'b0;
	endtask

	task automatic ask(input logic nn, input logic [4:0] c);
		aq.push_back(82'({nn, c}));
		// The control port polls the pending line before it asks.
		@(negedge aclk);
		chk(pend, nn ? 8'h00 : 8'h01 << desig);
		@(posedge aclk);
		ask_v[desig] <= 1'b1;
		@(posedge aclk);
		ask_v[desig] <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask

	task automatic note(input int i, input logic r, input logic pe, input logic [71:0] d);
		dq.push_back(r ? {1'b1, pe, d, 8'h01 << i} : {2'b00, 72'h0, 8'h01 << i});
	endtask

	// A cyc of -1 expects a refusal; a positive cyc is the exact answer time.
	task automatic acc(input int i, input logic w, input logic [17:0] a, input logic [71:0] d,
		input int cyc);
		int n;
		int gn;
		logic hit;
		logic rj;
		we[i] <= w;
		addr[i*18+:18] <= a;
		wd[i*72+:72] <= d;
		req[i] <= 1'b1;
		n = 0;
		gn = 0;
		hit = 1'b0;
		rj = 1'b0;
		while (!hit && n < 200) begin
			@(negedge aclk);
			n++;
			if (grant[i]) gn = n;
			rj = rej[i];
			hit = done[i] || rj;
		end
		@(posedge aclk);
		req[i] <= 1'b0;
		if (n >= 200) to();
		if (cyc < 0) chk(rj, 1'b1);
		if (cyc < 0) chk(gn, 0);
		if (cyc > 0) chk(n, cyc);
		if (cyc > 0) chk(gn, 2);
		@(posedge aclk);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h899A));
		{aresetn, awv, wv, bready, arv, rready, fast, ilv2, ilv4, ctl, bad} = 11'h0;
		{awaddr, araddr, req, we, iset_v, ask_v, wdata, prio} = 83'h0;
		{addr, wd, icell} = 760'h0;
		desig = 3'($urandom_range(7));
		ien = ($urandom | 32'h1230) & ~32'h8;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		rd(mhic_pkg::REG_LOCK, mhic_pkg::RESP_OKAY, 32'h0);
		rd(mhic_pkg::REG_IEN, mhic_pkg::RESP_OKAY, 32'h0);
		rd(mhic_pkg::REG_STS, mhic_pkg::RESP_OKAY, 32'h0);
		rd(8'h20, mhic_pkg::RESP_SLVERR, 32'h0);
		rd(mhic_pkg::REG_SW, mhic_pkg::RESP_OKAY, 32'({desig, prio} << 0));
		rd(mhic_pkg::REG_THI, mhic_pkg::RESP_OKAY, 32'h0);
		wr(mhic_pkg::REG_MSK, 32'h1);
		wr(mhic_pkg::REG_IEN, ien);
		rd(mhic_pkg::REG_IEN, mhic_pkg::RESP_OKAY, ien);
		iset(2, 5'h05);
		repeat (2) @(negedge aclk);
		chk(irq, 1'b1);
		chk(pend, 8'h01 << desig);
		@(posedge aclk);
		rd(mhic_pkg::REG_CELLS, mhic_pkg::RESP_OKAY, 32'h20);
		rd(mhic_pkg::REG_STS, mhic_pkg::RESP_OKAY, 32'h1);
		@(negedge aclk);
		chk(irq, 1'b0);
		@(posedge aclk);
		ask(1'b0, 5'h05);
		ask_v[3'(desig + 3'h1)] <= 1'b1;
		@(posedge aclk);
		ask_v <= 8'h00;
		iset(0, 5'h09);
		iset(7, 5'h04);
		@(posedge aclk);
		iset(7, 5'h04);
		ask(1'b0, 5'h04);
		ask(1'b0, 5'h09);
		ask(1'b1, 5'h00);
		iset(1, 5'h03);
		ask(1'b1, 5'h00);
		wr(mhic_pkg::REG_IEN, ien | 32'h8);
		ask(1'b0, 5'h03);
		wr(mhic_pkg::REG_LOCK, 32'h2);
		iset(1, 5'h0C);
		rd(mhic_pkg::REG_CELLS, mhic_pkg::RESP_OKAY, 32'h0);
		acc(1, 1'b0, 18'h0, 72'h0, -1);
		rd(mhic_pkg::REG_STS, mhic_pkg::RESP_OKAY, 32'h3);
		wr(mhic_pkg::REG_LOCK, 32'h0);
		for (int m = 0; m < 4; m++) begin
			fast <= m[0];
			ilv2 <= (m == 1);
			ilv4 <= (m >= 2);
			prio <= (m == 3) ? 3'h5 : 3'h0;
			repeat (4) @(posedge aclk);
			a3 = 18'($urandom) & 18'h3FFFD;
			a6 = 18'($urandom) & 18'h3FFFD;
			d3 = 72'({$urandom, $urandom, $urandom});
			d6 = 72'({$urandom, $urandom, $urandom});
			// Request to done: one edge to take, the cycle, then the done pulse.
			ncyc = (fast ? mhic_pkg::MEM_FAST_CYC : mhic_pkg::MEM_SLOW_CYC) + 2;
			if (m == 3) note(6, 1'b0, 1'b0, d6);
			note(3, 1'b0, 1'b0, d3);
			if (m != 3) note(6, 1'b0, 1'b0, d6);
			fork
				acc(3, 1'b1, a3, d3, 0);
				acc(6, 1'b1, a6, d6, 0);
			join
			note(3, 1'b1, 1'b0, d3);
			acc(3, 1'b0, a3, 72'h0, ncyc);
			note(6, 1'b1, 1'b0, d6);
			acc(6, 1'b0, a6, 72'h0, ncyc);
		end
		bad <= 1'b1;
		note(3, 1'b1, 1'b1, d3);
		acc(3, 1'b0, a3, 72'h0, 0);
		bad <= 1'b0;
		rd(mhic_pkg::REG_STS, mhic_pkg::RESP_OKAY, 32'h4);
		repeat (4) @(posedge aclk);
		wrap_up();
	end
endmodule
